//--- verilog/sws_pkg.sv
// Shared constants for the serial to single-wire command interpreter
`default_nettype none
package sws_pkg;
   localparam int CLK_NS = 5;
   localparam int T_PROG_US = 512;
   localparam int T_SPU_MS = 524;
   localparam int T_RSTLOW_US = 480;
   localparam int T_PRES_US = 70;
   localparam int T_SLOT_US = 70;
   localparam int T_W0_US = 60;
   localparam int T_W1_US = 6;
   localparam int T_SAMP_US = 15;
   // Least times round up to whole clock cycles
   localparam int PROG_CYC = (T_PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SPU_CYC = (T_SPU_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int RSTLOW_CYC = (T_RSTLOW_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int PRES_CYC = (T_PRES_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SLOT_CYC = (T_SLOT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int W0_CYC = (T_W0_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int W1_CYC = (T_W1_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SAMP_CYC = (T_SAMP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] CMD_DATA = 8'hE1;
   localparam logic [7:0] CMD_CMD = 8'hE3;
   localparam logic [7:0] CMD_RST = 8'hC1;
   localparam logic [7:0] CMD_ARM = 8'hEF;
   localparam logic [7:0] CMD_DISARM = 8'hED;
   localparam logic [7:0] CMD_TERM = 8'hF1;
   localparam logic [7:0] CMD_PROG = 8'hFD;
   localparam logic [2:0] PAR_PROG = 3'h2;
   localparam logic [2:0] PAR_SPU = 3'h3;
   localparam logic [2:0] SEL_RST = 3'h4;
   localparam logic [7:0] RESP_MASK = 8'hFE;
   localparam logic [7:0] RESP_PRES = 8'hCD;
   localparam logic [7:0] RESP_NOPRES = 8'hCF;
   localparam logic [7:0] RESP_SPU = 8'hEE;
   localparam int AXI_AW = 4;
   localparam logic [AXI_AW-1:0] ADDR_CTRL = 4'h0;
   localparam logic [AXI_AW-1:0] ADDR_STAT = 4'h4;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam int POL_BIT = 2;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum logic [2:0] {S_IDLE, S_SLOT, S_RST, S_PULSE, S_RESP} sws_state_t;
   // Bit period in clocks for 9600, 19200, 57600, 115200 baud
   function automatic logic [15:0] baud_div(input logic [1:0] code);
      unique case (code)
         2'h0: baud_div = 16'h5161;
         2'h1: baud_div = 16'h28B1;
         2'h2: baud_div = 16'h0D90;
         default: baud_div = 16'h06C8;
      endcase
   endfunction
endpackage
`default_nettype wire

//--- verilog/sws_uart_if.sv
// Byte link between the interpreter core and the serial port
`default_nettype none
interface sws_uart_if;
   logic [15:0] divisor;
   logic serial_polarity_select;
   logic rx_valid;
   logic [7:0] rx_data;
   logic tx_valid;
   logic [7:0] tx_data;
   logic tx_ready;
   modport core (output divisor, serial_polarity_select, tx_valid, tx_data,
      input rx_valid, rx_data, tx_ready);
   modport phy (input divisor, serial_polarity_select, tx_valid, tx_data,
      output rx_valid, rx_data, tx_ready);
endinterface
`default_nettype wire

//--- verilog/sws_uart.sv
// Serial port with selectable line polarity, 8N1
`default_nettype none
module sws_uart (
   input wire logic mclk,
   input wire logic srst,
   input wire logic rx_pin,
   output logic tx_pin,
   sws_uart_if.phy u
);
   logic r1, r2;
   logic rx_busy, rx_vld;
   logic [15:0] rx_cnt, tx_cnt;
   logic [3:0] rx_bit, tx_bit;
   logic [7:0] rx_sh, rx_dat;
   logic tx_busy;
   logic [9:0] tx_sh;
   wire rxl = r2 ^ u.serial_polarity_select;
   wire tx_line = tx_busy ? tx_sh[0] : 1'b1;
   assign u.rx_valid = rx_vld;
   assign u.rx_data = rx_dat;
   assign u.tx_ready = ~tx_busy;

   always_ff @(posedge mclk)
   begin
      r1 <= rx_pin;
      r2 <= r1;
   end

   // Start bit is checked at mid-bit so a glitch does not frame a byte
   always_ff @(posedge mclk)
   begin
      rx_vld <= 1'b0;
      if (srst)
      begin
         rx_busy <= 1'b0;
         rx_cnt <= 16'h0000;
         rx_bit <= 4'h0;
      end
      else if (!rx_busy)
      begin
         rx_busy <= ~rxl;
         rx_cnt <= u.divisor >> 1;
         rx_bit <= 4'h0;
      end
      else if (rx_cnt != 16'h0000)
         rx_cnt <= rx_cnt - 16'h0001;
      else
      begin
         rx_cnt <= u.divisor - 16'h0001;
         rx_bit <= rx_bit + 4'h1;
         if (rx_bit == 4'h0 && rxl)
            rx_busy <= 1'b0;
         else if (rx_bit == 4'h9)
         begin
            rx_busy <= 1'b0;
            rx_vld <= rxl;
            rx_dat <= rx_sh;
         end
         else
            rx_sh <= {rxl, rx_sh[7:1]};
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         tx_busy <= 1'b0;
         tx_cnt <= 16'h0000;
         tx_bit <= 4'h0;
      end
      else if (!tx_busy)
      begin
         tx_busy <= u.tx_valid;
         tx_sh <= {1'b1, u.tx_data, 1'b0};
         tx_cnt <= u.divisor - 16'h0001;
         tx_bit <= 4'h0;
      end
      else if (tx_cnt != 16'h0000)
         tx_cnt <= tx_cnt - 16'h0001;
      else
      begin
         tx_cnt <= u.divisor - 16'h0001;
         tx_bit <= tx_bit + 4'h1;
         tx_sh <= {1'b1, tx_sh[9:1]};
         tx_busy <= tx_bit != 4'h9;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         tx_pin <= 1'b1;
      else
         tx_pin <= tx_line ^ u.serial_polarity_select;
   end
endmodule // sws_uart
`default_nettype wire

//--- verilog/sws_top.sv
// Serial to single-wire bridge: command interpreter, bus timing, register slave
`default_nettype none
module sws_top #(
   parameter int P_PROG = sws_pkg::PROG_CYC,
   parameter int P_SPU = sws_pkg::SPU_CYC,
   parameter int P_RSTLOW = sws_pkg::RSTLOW_CYC,
   parameter int P_PRES = sws_pkg::PRES_CYC,
   parameter int P_SLOT = sws_pkg::SLOT_CYC,
   parameter int P_W0 = sws_pkg::W0_CYC,
   parameter int P_W1 = sws_pkg::W1_CYC,
   parameter int P_SAMP = sws_pkg::SAMP_CYC
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [sws_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sws_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ser_rx_pin,
   output logic ser_tx_pin,
   input wire logic bus_in,
   output logic bus_out,
   output logic bus_oe_n,
   output logic spu_en,
   output logic vpp_en
);
   localparam int CW = 27;
   initial
   begin
      if (!(P_W1 < P_SAMP && P_SAMP < P_W0 && P_W0 < P_SLOT && P_PRES < P_RSTLOW
            && P_SPU < 2 ** CW && P_PROG < 2 ** CW && P_W1 > 0))
         $error("sws_top: bus timing parameters out of range");
   end
   localparam logic [CW-1:0] PROG_L = CW'(P_PROG - 1);
   localparam logic [CW-1:0] SPU_L = CW'(P_SPU - 1);
   localparam logic [CW-1:0] RSTLOW_C = CW'(P_RSTLOW);
   localparam logic [CW-1:0] PRES_L = CW'(P_RSTLOW + P_PRES - 1);
   localparam logic [CW-1:0] RSTEND_L = CW'(2 * P_RSTLOW - 1);
   localparam logic [CW-1:0] SLOT_L = CW'(P_SLOT - 1);
   localparam logic [CW-1:0] W0_C = CW'(P_W0);
   localparam logic [CW-1:0] W1_C = CW'(P_W1);
   localparam logic [CW-1:0] SAMP_L = CW'(P_SAMP - 1);

   sws_uart_if u_if ();
   sws_pkg::sws_state_t st;
   logic [CW-1:0] cnt;
   logic [2:0] bitn, ctrl, prog_sel, spu_sel;
   logic [7:0] hold, shreg, resp;
   logic have, mode_data, armed, wbit, pres, pend, txv, b1, bus_s;

   sws_uart u_uart (
      .mclk(mclk),
      .srst(srst),
      .rx_pin(ser_rx_pin),
      .tx_pin(ser_tx_pin),
      .u(u_if.phy)
   );
   assign u_if.divisor = sws_pkg::baud_div(ctrl[1:0]);
   assign u_if.serial_polarity_select = ctrl[sws_pkg::POL_BIT];
   assign u_if.tx_valid = txv;
   assign u_if.tx_data = resp;

   wire cmd_mode = ~mode_data;
   wire go = st == sws_pkg::S_IDLE && have;
   wire go_cmd = go && cmd_mode;
   wire is_cfg = !hold[7] && hold[0]
      && (hold[6:4] == sws_pkg::PAR_PROG || hold[6:4] == sws_pkg::PAR_SPU);
   wire is_pulse = hold == sws_pkg::CMD_ARM || hold == sws_pkg::CMD_DISARM;
   wire term = st == sws_pkg::S_PULSE && have && cmd_mode && hold == sws_pkg::CMD_TERM;
   wire take = go || term;
   wire pulse_end = term || cnt == (vpp_en ? PROG_L : SPU_L);
   wire fire = txv && u_if.tx_ready;
   wire cnt_clr = st == sws_pkg::S_IDLE || st == sws_pkg::S_RESP
      || (st == sws_pkg::S_SLOT && cnt == SLOT_L);
   wire slot_low = st == sws_pkg::S_SLOT && cnt < (wbit ? W1_C : W0_C);
   wire rst_low = st == sws_pkg::S_RST && cnt < RSTLOW_C;

   // Bus input crosses from the pin; sample only the second stage
   always_ff @(posedge mclk)
   begin
      b1 <= bus_in;
      bus_s <= b1;
   end

   // A byte arriving while one waits overwrites it; host must pace itself
   always_ff @(posedge mclk)
   begin
      if (srst)
         have <= 1'b0;
      else if (u_if.rx_valid)
         have <= 1'b1;
      else if (take)
         have <= 1'b0;
      if (u_if.rx_valid)
         hold <= u_if.rx_data;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         mode_data <= 1'b0;
      else if (go_cmd && hold == sws_pkg::CMD_DATA)
         mode_data <= 1'b1;
      else if (go && hold == sws_pkg::CMD_CMD)
         mode_data <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         armed <= 1'b0;
         prog_sel <= sws_pkg::SEL_RST;
         spu_sel <= sws_pkg::SEL_RST;
      end
      else if (go_cmd && is_pulse)
         armed <= hold == sws_pkg::CMD_ARM;
      else if (go_cmd && is_cfg && hold[6:4] == sws_pkg::PAR_PROG)
         prog_sel <= hold[3:1];
      else if (go_cmd && is_cfg)
         spu_sel <= hold[3:1];
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         spu_en <= 1'b0;
         vpp_en <= 1'b0;
      end
      else if (st == sws_pkg::S_PULSE && pulse_end)
      begin
         spu_en <= 1'b0;
         vpp_en <= 1'b0;
      end
      else if ((go_cmd && is_pulse) || (st == sws_pkg::S_RESP && fire && pend))
         spu_en <= 1'b1;
      else if (go_cmd && hold == sws_pkg::CMD_PROG)
         vpp_en <= 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         cnt <= '0;
      else
         cnt <= cnt_clr ? '0 : cnt + CW'(1);
   end

   // Bus pin is open drain: the output stays low, only the enable moves
   always_ff @(posedge mclk)
   begin
      bus_out <= 1'b0;
      if (srst)
         bus_oe_n <= 1'b1;
      else
         bus_oe_n <= ~(slot_low | rst_low);
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st <= sws_pkg::S_IDLE;
         txv <= 1'b0;
         pend <= 1'b0;
         pres <= 1'b0;
         bitn <= 3'h0;
         wbit <= 1'b1;
         shreg <= 8'h00;
         resp <= 8'h00;
      end
      else
      begin
         unique case (st)
            sws_pkg::S_IDLE:
            begin
               bitn <= 3'h0;
               pres <= 1'b0;
               shreg <= hold;
               wbit <= hold[0];
               if (go && mode_data && hold != sws_pkg::CMD_CMD)
                  st <= sws_pkg::S_SLOT;
               else if (go_cmd && is_cfg)
               begin
                  resp <= hold & sws_pkg::RESP_MASK;
                  st <= sws_pkg::S_RESP;
               end
               else if (go_cmd && hold == sws_pkg::CMD_RST)
                  st <= sws_pkg::S_RST;
               else if (go_cmd && (is_pulse || hold == sws_pkg::CMD_PROG))
               begin
                  resp <= hold & sws_pkg::RESP_MASK;
                  st <= sws_pkg::S_PULSE;
               end
            end
            sws_pkg::S_SLOT:
            begin
               if (cnt == SAMP_L)
                  shreg <= {bus_s, shreg[7:1]};
               if (cnt == SLOT_L)
               begin
                  wbit <= shreg[0];
                  bitn <= bitn + 3'h1;
                  if (bitn == 3'h7)
                  begin
                     resp <= shreg;
                     pend <= armed;
                     st <= sws_pkg::S_RESP;
                  end
               end
            end
            sws_pkg::S_RST:
            begin
               if (cnt == PRES_L)
                  pres <= ~bus_s;
               if (cnt == RSTEND_L)
               begin
                  resp <= pres ? sws_pkg::RESP_PRES : sws_pkg::RESP_NOPRES;
                  st <= sws_pkg::S_RESP;
               end
            end
            sws_pkg::S_PULSE:
            begin
               if (pulse_end)
                  st <= sws_pkg::S_RESP;
            end
            sws_pkg::S_RESP:
            begin
               if (!fire)
                  txv <= 1'b1;
               else
               begin
                  txv <= 1'b0;
                  pend <= 1'b0;
                  if (pend)
                  begin
                     resp <= sws_pkg::RESP_SPU;
                     st <= sws_pkg::S_PULSE;
                  end
                  else
                     st <= sws_pkg::S_IDLE;
               end
            end
         endcase
      end
   end

   // Register slave: address and data are taken together, at most one write and one read in flight at once
   wire aw_ok = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   wire ar_ok = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   wire wr_ctrl = s_axi_awaddr == sws_pkg::ADDR_CTRL;
   wire rd_ctrl = s_axi_araddr == sws_pkg::ADDR_CTRL;
   wire rd_stat = s_axi_araddr == sws_pkg::ADDR_STAT;
   wire [31:0] stat = {20'h00000, prog_sel, spu_sel, st != sws_pkg::S_IDLE, have,
      armed, vpp_en, spu_en, mode_data};
   wire [31:0] rd_word = rd_ctrl ? {29'h00000000, ctrl} : (rd_stat ? stat : 32'h00000000);

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sws_pkg::AXI_OKAY;
         ctrl <= sws_pkg::CTRL_RST;
      end
      else
      begin
         s_axi_awready <= aw_ok;
         s_axi_wready <= aw_ok;
         if (s_axi_awready)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_ctrl || s_axi_awaddr == sws_pkg::ADDR_STAT)
               ? sws_pkg::AXI_OKAY : sws_pkg::AXI_SLVERR;
            if (wr_ctrl && s_axi_wstrb[0])
               ctrl <= s_axi_wdata[2:0];
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= sws_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_arready <= ar_ok;
         if (s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_ctrl || rd_stat) ? sws_pkg::AXI_OKAY : sws_pkg::AXI_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   property p_cfg_prog;
      @(posedge mclk) disable iff (srst)
      go_cmd && hold == 8'h29 |=> st == sws_pkg::S_RESP && resp == 8'h28 && prog_sel == 3'h4;
   endproperty
   a_cfg_prog: assert property (p_cfg_prog) else $error("config 29h not answered 28h");
   property p_cfg_spu;
      @(posedge mclk) disable iff (srst)
      go_cmd && hold == 8'h39 |=> resp == 8'h38 ##1 txv;
   endproperty
   a_cfg_spu: assert property (p_cfg_spu) else $error("config 39h not answered 38h");
   property p_rst;
      @(posedge mclk) disable iff (srst)
      go_cmd && hold == 8'hC1 |=> st == sws_pkg::S_RST ##1 !bus_oe_n;
   endproperty
   a_rst: assert property (p_rst) else $error("reset command did not pull the bus");
   property p_arm;
      @(posedge mclk) disable iff (srst)
      go_cmd && hold == 8'hEF |=> armed && spu_en && !txv;
   endproperty
   a_arm: assert property (p_arm) else $error("arm pulse wrong");
   property p_term;
      @(posedge mclk) disable iff (srst)
      term |=> !spu_en && !vpp_en && st == sws_pkg::S_RESP ##1 txv;
   endproperty
   a_term: assert property (p_term) else $error("termination did not end pulse");
   property p_prog;
      @(posedge mclk) disable iff (srst)
      go_cmd && hold == 8'hFD |=> vpp_en && resp == 8'hFC;
   endproperty
   a_prog: assert property (p_prog) else $error("program pulse not started");
   property p_spu_data;
      @(posedge mclk) disable iff (srst)
      st == sws_pkg::S_RESP && fire && pend |=> spu_en && st == sws_pkg::S_PULSE
         && resp == 8'hEE;
   endproperty
   a_spu_data: assert property (p_spu_data) else $error("armed pullup missing");
   property p_data;
      @(posedge mclk) disable iff (srst)
      go && mode_data && hold != 8'hE3 |=> st == sws_pkg::S_SLOT ##2 !bus_oe_n;
   endproperty
   a_data: assert property (p_data) else $error("data byte did not start a slot");
   property p_mode;
      @(posedge mclk) disable iff (srst)
      go_cmd && hold == 8'hE1 |=> mode_data && st == sws_pkg::S_IDLE && !txv;
   endproperty
   a_mode: assert property (p_mode) else $error("data mode switch wrong");
   property p_buf;
      @(posedge mclk) disable iff (srst)
      u_if.rx_valid |=> have && hold == $past(u_if.rx_data);
   endproperty
   a_buf: assert property (p_buf) else $error("received byte not buffered");
   property p_pol;
      @(posedge mclk) disable iff (srst)
      $changed(ctrl[2]) && u_if.tx_ready && !txv |=> ##1 ser_tx_pin == !ctrl[2];
   endproperty
   a_pol: assert property (p_pol) else $error("idle line polarity wrong");
   c_reset: cover property (@(posedge mclk) st == sws_pkg::S_RST ##1 st == sws_pkg::S_RESP);
   c_term: cover property (@(posedge mclk) term);
   c_spu: cover property (@(posedge mclk) st == sws_pkg::S_RESP && fire && pend);
endmodule // sws_top
`default_nettype wire

//--- bench/sws_host.sv
// Host serial port model: sends and collects 8N1 bytes
`default_nettype none
module sws_host #(
   parameter int BIT = 1736
) (
   input wire logic mclk,
   input wire logic rx_pin,
   output logic tx_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic inv = 1'b0;
   logic raw = 1'b1;
   logic [7:0] d;
   logic [7:0] rxq[$];
   assign tx_pin = raw ^ inv;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         raw <= f[i];
         repeat (BIT) @(posedge mclk);
      end
      // Short idle gap kept by the host, not left to chance
      repeat (BIT / 4) @(posedge mclk);
   endtask
   // Start bit rechecked mid-bit so a polarity switch is not taken for a byte
   always
   begin
      @(posedge mclk);
      if ((rx_pin ^ inv) === 1'b0)
      begin
         repeat (BIT / 2) @(posedge mclk);
         if ((rx_pin ^ inv) === 1'b0)
         begin
            for (int i = 0; i < 8; i++)
            begin
               repeat (BIT) @(posedge mclk);
               d[i] = rx_pin ^ inv;
            end
            repeat (BIT) @(posedge mclk);
            rxq.push_back(d);
         end
      end
   end
endmodule // sws_host
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the serial to single-wire bridge
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [sws_pkg::AXI_AW-1:0] awaddr = 4'h0;
   logic [sws_pkg::AXI_AW-1:0] araddr = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic rx, tx, bus_out, oe_n, spu, vpp;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic bus_in = 1'b1;
   logic slv_on = 1'b0;
   logic [7:0] sbyte = 8'hFF;
   logic [7:0] seq[6] = '{8'h39, 8'hC1, 8'hFD, 8'hEF, 8'hF1, 8'hE1};
   logic [31:0] expq[$];
   int pl = 0;
   int lowc = 0;
   int vpp_cnt = 0;
   int spu_cnt = 0;
   int fail_count = 0;
   int compares = 0;
   bit dm = 1'b0;
   bit armed = 1'b0;
   always #2.5 mclk = ~mclk;
   sws_host host_inst (.mclk(mclk), .rx_pin(tx), .tx_pin(rx));
   // Long pulse kept so F1 can end the armed pulse before its own timeout
   sws_top #(.P_PROG(400), .P_SPU(40000), .P_RSTLOW(200), .P_PRES(40), .P_SLOT(100),
      .P_W0(80), .P_W1(10), .P_SAMP(30)) sws_top_inst (.mclk(mclk), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ser_rx_pin(rx), .ser_tx_pin(tx), .bus_in(bus_in), .bus_out(bus_out),
      .bus_oe_n(oe_n), .spu_en(spu), .vpp_en(vpp));
   // Bus slave: presence after a long low, zero bits stretched past the sample point
   always @(posedge mclk)
   begin
      lowc <= (oe_n !== 1'b0) ? 0 : lowc + 1;
      if (oe_n === 1'b1 && lowc > 150)
         pl <= 60;
      else if (oe_n === 1'b0 && lowc == 0 && slv_on)
      begin
         pl <= sbyte[0] ? 0 : 60;
         sbyte <= {1'b1, sbyte[7:1]};
      end
      else if (pl > 0)
         pl <= pl - 1;
      bus_in <= (oe_n !== 1'b0) && pl == 0;
      vpp_cnt <= vpp_cnt + int'(vpp === 1'b1);
      spu_cnt <= spu_cnt + int'(spu === 1'b1);
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic guard(input int n, input int lim);
      if (n >= lim)
      begin
         fail_count++;
         end_sim();
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && n < 100);
      bready <= 1'b0;
      rs = bresp;
      guard(n, 100);
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1 && n < 100);
      rready <= 1'b0;
      d = rdata;
      rs = rresp;
      guard(n, 100);
   endtask
   // Reference model of the answers, then the byte goes out on the wire
   task automatic host_byte(input logic [7:0] b);
      if (!dm)
         case (b)
            8'h29: expq.push_back(8'h28);
            8'h39: expq.push_back(8'h38);
            8'hC1: expq.push_back(8'hCD);
            8'hFD: expq.push_back(8'hFC);
            8'hEF: armed = 1'b1;
            8'hF1: expq.push_back(8'hEE);
            8'hE1: dm = 1'b1;
            default: ;
         endcase
      else
      begin
         expq.push_back({24'h0, b & sbyte});
         if (armed)
            expq.push_back(8'hEE);
      end
      host_inst.send(b);
   endtask
   task automatic drain(input int n);
      int k;
      k = 0;
      while (host_inst.rxq.size() < n && k < 300000)
      begin
         @(posedge mclk);
         k++;
      end
      guard(k, 300000);
      repeat (n) check({24'h0, host_inst.rxq.pop_front()}, expq.pop_front());
   endtask
   initial
   begin
      logic [31:0] v;
      logic [1:0] rs;
      logic [7:0] hb;
      v = $urandom(11262);
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      axi_rd(4'h4, v, rs);
      check(v, 32'h900);
      axi_wr(4'h0, 32'h3, rs);
      check({30'h0, rs}, 32'h0);
      axi_rd({1'b1, 1'($urandom), 2'h0}, v, rs);
      check({v[31:2], rs}, 32'h2);
      axi_wr(4'hC, $urandom, rs);
      check({30'h0, rs}, 32'h2);
      // Baud field sits in byte lane 0: a write without that lane must not land
      wstrb <= 4'hE;
      @(posedge mclk);
      axi_wr(4'h0, 32'h0, rs);
      wstrb <= 4'hF;
      check({30'h0, rs}, 32'h0);
      axi_rd(4'h0, v, rs);
      check(v, 32'h3);
      $display("test registers done");
      host_byte(8'h29);
      drain(1);
      $display("test normal polarity done");
      axi_wr(4'h0, 32'h7, rs);
      host_inst.inv <= 1'b1;
      axi_rd(4'h0, v, rs);
      check({29'h0, v[2:0]}, 32'h7);
      hb = 8'($urandom);
      sbyte <= 8'($urandom);
      // Bytes go out one ahead of execution; the device buffers one
      foreach (seq[i])
         host_byte(seq[i]);
      slv_on <= 1'b1;
      host_byte(hb);
      drain(6);
      check(vpp_cnt, 32'h190);
      check({31'h0, spu_cnt >= 40000}, 32'h1);
      axi_wr(4'h4, 32'hFFF, rs);
      check({30'h0, rs}, 32'h0);
      axi_rd(4'h4, v, rs);
      check(v, 32'h909);
      check({31'h0, bus_out}, 32'h0);
      $display("test inverted sequence done");
      // Second reset mid-run: mode, arming and baud setting return to their reset state
      srst <= 1'b1;
      host_inst.inv <= 1'b0;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      axi_rd(4'h4, v, rs);
      check(v, 32'h900);
      @(posedge mclk);
      axi_rd(4'h0, v, rs);
      check(v, 32'h0);
      $display("test reset done");
      end_sim();
   end
endmodule // tb
`default_nettype wire
